// ### dv/interrupt_vector_address_unit_tb.sv
// Testbench of the interrupt vector address unit
`timescale 1ns/100ps
`include "ivau_params.svh"
module interrupt_vector_address_unit_tb;
  localparam logic [15:0] BOOT = `IVAU_BOOT_ADDR_DEF;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fuse = 1'b1;
  logic sel = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [23:0] irq = 24'h000000;
  logic ack, vld, isr, s_vld;
  logic [4:0] num;
  logic [15:0] addr;
  ivau_pkg::ivau_fetch_t got;
  int n_errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  ivau_top i_dut (.clk_i(clk), .rst_i(rst), .boot_reset_fuse_i(fuse), .vector_table_select_i(sel),
    .irq_i(irq), .fetch_ack_i(ack), .fetch_valid_o(vld), .fetch_is_reset_o(isr), .vec_num_o(num),
    .vec_addr_o(addr));
  ivau_top #(.LARGE_PINS(1'b0)) i_small (.clk_i(clk), .rst_i(rst), .boot_reset_fuse_i(fuse),
    .vector_table_select_i(sel), .irq_i(irq), .fetch_ack_i(1'b1), .fetch_valid_o(s_vld),
    .fetch_is_reset_o(), .vec_num_o(), .vec_addr_o());
  ivau_core_model i_core (.clk_i(clk), .rst_i(rst), .valid_i(vld), .is_reset_i(isr), .num_i(num),
    .addr_i(addr), .lag_i(lag), .ack_o(ack), .got_o(got));
  // ==========================
  // Shared tasks
  task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic take(input logic r, input logic [4:0] n, input logic [15:0] a, input logic [23:0] clr);
    int k;
    k = 0;
    @(negedge clk);
    while (!(vld === 1'b1 && ack === 1'b1) && k < 60) begin
      @(negedge clk);
      k++;
    end
    @(posedge clk);
    irq <= irq & ~clr;
    if (k >= 60) begin
      n_errors++;
      $display("BAD %0t no handshake", $time);
    end
    #1 chk(got, {1'b1, r, n, a});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================
  // Scenarios
  task automatic t_reset(input logic f, input logic s);
    @(posedge clk);
    fuse <= f;
    sel <= s;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    take(1'b1, 5'h01, f ? 16'h0000 : BOOT, 24'h000000);
  endtask
  task automatic t_each(input logic s, input logic [15:0] base, input logic [3:0] l);
    @(posedge clk);
    sel <= s;
    lag <= l;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      irq <= 24'h000001 << i;
      take(1'b0, 5'(i + 2), base + 16'(2 * (i + 1)), 24'h000001 << i);
    end
  endtask
  task automatic t_prio;
    @(posedge clk);
    lag <= 4'h3;
    irq <= 24'h800005;
    take(1'b0, 5'h02, 16'h0002, 24'h000001);
    take(1'b0, 5'h04, 16'h0006, 24'h000004);
    take(1'b0, 5'h19, 16'h0030, 24'h800000);
  endtask
  task automatic t_small;
    @(posedge clk);
    lag <= 4'h8;
    irq <= 24'hc00000;
    repeat (3) begin
      @(posedge clk);
      #1 chk(23'(s_vld), 23'h000000);
    end
    take(1'b0, 5'h18, 16'h002e, 24'h400000);
    take(1'b0, 5'h19, 16'h0030, 24'h800000);
  endtask
  initial begin
    for (int j = 0; j < 4; j++) begin
      t_reset(~j[1], j[0]);
    end
    t_each(1'b0, 16'h0000, 4'h0);
    t_prio();
    t_small();
    t_each(1'b1, BOOT, 4'h2);
    tally_and_finish();
  end
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule

// ### dv/ivau_core_model.sv
// Core model that takes offered vectors after a set lag
`timescale 1ns/100ps
module ivau_core_model
  import ivau_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire logic is_reset_i,
  input wire logic [4:0] num_i,
  input wire logic [15:0] addr_i,
  input wire logic [3:0] lag_i,
  output logic ack_o,
  output ivau_fetch_t got_o
);
  logic [3:0] wait_q;
  // ==========================
  // Ack after lag_i+1 offered cycles, record taken vector
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_q <= 4'h0;
      got_o <= '0;
    end else if (valid_i && ack_o) begin
      got_o <= '{1'b1, is_reset_i, num_i, addr_i};
      ack_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (valid_i) begin
      wait_q <= wait_q + 4'h1;
      ack_o <= (wait_q >= lag_i);
    end
  end
endmodule

// ### hdl/ivau_params.svh
// Constants of the interrupt vector address unit
`ifndef IVAU_PARAMS_SVH
`define IVAU_PARAMS_SVH
`define IVAU_RESET_ADDR 16'h0000
`define IVAU_TABLE_BASE 16'h0002
`define IVAU_VEC_STEP 16'h0002
`define IVAU_BOOT_ADDR_DEF 16'h3800
`define IVAU_NUM_SRC 24
`define IVAU_NUM_SRC_SMALL 22
`define IVAU_SRC_W 5
`define IVAU_RESET_VEC 5'h01
`define IVAU_FIRST_IRQ_VEC 5'h02
`endif

// ### hdl/ivau_pkg.sv
// Types of the interrupt vector address unit
package ivau_pkg;
  typedef enum logic [1:0] {
    IVAU_IDLE = 2'b00,
    IVAU_RESET = 2'b01,
    IVAU_VECTOR = 2'b10
  } ivau_state_t;

  typedef struct packed {
    logic valid;
    logic is_reset;
    logic [4:0] vec_num;
    logic [15:0] addr;
  } ivau_fetch_t;

  typedef struct packed {
    ivau_state_t state;
    ivau_fetch_t fetch;
  } ivau_reg_t;
endpackage

// ### hdl/ivau_prio.sv
// Fixed-priority selector: lowest request index wins
`timescale 1ns/100ps
module ivau_prio #(
  parameter int N = 24,
  parameter int W = 5
) (
  input wire logic [N-1:0] req_i,
  output logic any_o,
  output logic [W-1:0] idx_o
);
  if (N > (1 << W) || N < 1) begin : g_bad_size
    $error("ivau_prio: N does not fit W");
  end

  logic [N-1:0] hit;
  logic [N-1:0] below;
  // ==========================================
  // One-hot of lowest set bit
  generate
    for (genvar g = 0; g < N; g++) begin : g_bit
      if (g == 0) begin : g_first
        assign below[g] = 1'b0;
      end else begin : g_rest
        assign below[g] = below[g-1] | req_i[g-1];
      end
      assign hit[g] = req_i[g] & ~below[g];
    end
  endgenerate

  always_comb begin
    idx_o = '0;
    for (int i = 0; i < N; i++) begin
      if (hit[i]) begin
        idx_o = W'(i);
      end
    end
  end
  assign any_o = |req_i;
endmodule

// ### hdl/ivau_top.sv
// Interrupt vector address unit: reset and interrupt vector generation
`timescale 1ns/100ps
`include "ivau_params.svh"
module ivau_top
  import ivau_pkg::*;
#(
  parameter bit LARGE_PINS = 1'b1,
  parameter logic [15:0] BOOT_ADDR = `IVAU_BOOT_ADDR_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic boot_reset_fuse_i,
  input wire logic vector_table_select_i,
  input wire logic [`IVAU_NUM_SRC-1:0] irq_i,
  input wire logic fetch_ack_i,
  output logic fetch_valid_o,
  output logic fetch_is_reset_o,
  output logic [4:0] vec_num_o,
  output logic [15:0] vec_addr_o
);
  if (BOOT_ADDR[0] != 1'b0 || BOOT_ADDR > 16'hffce) begin : g_bad_boot
    $error("ivau_top: boot address must be even and leave room for the table");
  end

  // ==========================================
  // Source masking
  logic [`IVAU_NUM_SRC-1:0] req_ok;
  always_comb begin
    req_ok = irq_i;
    if (!LARGE_PINS) begin
      req_ok[`IVAU_NUM_SRC-1:`IVAU_NUM_SRC_SMALL] = '0;
    end
  end

  logic any_req;
  logic [`IVAU_SRC_W-1:0] win_idx;
  ivau_prio #(
    .N(`IVAU_NUM_SRC),
    .W(`IVAU_SRC_W)
  ) u_prio (
    .req_i(req_ok),
    .any_o(any_req),
    .idx_o(win_idx)
  );

  // ==========================================
  // Address generation
  logic [15:0] reset_addr;
  logic [15:0] table_base;
  logic [15:0] irq_addr;
  logic [4:0] irq_num;
  assign reset_addr = boot_reset_fuse_i ? `IVAU_RESET_ADDR : BOOT_ADDR;
  assign table_base = vector_table_select_i ? 16'(BOOT_ADDR + `IVAU_TABLE_BASE) : `IVAU_TABLE_BASE;
  // Request index i is vector number i+2
  assign irq_num = 5'(win_idx) + `IVAU_FIRST_IRQ_VEC;
  assign irq_addr = 16'(table_base + 16'(`IVAU_VEC_STEP * {11'h000, win_idx}));

  // ==========================================
  // State
  ivau_reg_t s_q;
  ivau_reg_t s_d;

  always_comb begin
    s_d = s_q;
    unique case (s_q.state)
      IVAU_RESET: begin
        // Reset vector offered first after any reset
        s_d.fetch.valid = 1'b1;
        s_d.fetch.is_reset = 1'b1;
        s_d.fetch.vec_num = `IVAU_RESET_VEC;
        s_d.fetch.addr = reset_addr;
        if (s_q.fetch.valid && fetch_ack_i) begin
          s_d.state = IVAU_IDLE;
          s_d.fetch.valid = 1'b0;
        end
      end
      IVAU_IDLE: begin
        if (any_req) begin
          s_d.state = IVAU_VECTOR;
          s_d.fetch.valid = 1'b1;
          s_d.fetch.is_reset = 1'b0;
          s_d.fetch.vec_num = irq_num;
          s_d.fetch.addr = irq_addr;
        end
      end
      IVAU_VECTOR: begin
        if (fetch_ack_i) begin
          s_d.state = IVAU_IDLE;
          s_d.fetch.valid = 1'b0;
        end
      end
      default: begin
        s_d.state = IVAU_IDLE;
        s_d.fetch.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{state: IVAU_RESET, fetch: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_valid_o = s_q.fetch.valid;
  assign fetch_is_reset_o = s_q.fetch.is_reset;
  assign vec_num_o = s_q.fetch.vec_num;
  assign vec_addr_o = s_q.fetch.addr;

  // ==========================================
  // Checks
  sequence reset_release_s;
    $fell(rst_i);
  endsequence

  reset_vector_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && fetch_is_reset_o && $stable(boot_reset_fuse_i) && boot_reset_fuse_i)
      |-> vec_addr_o == 16'h0000 && vec_num_o == 5'h01)
    else $error("reset vector not at zero");

  boot_reset_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && fetch_is_reset_o && $stable(boot_reset_fuse_i) && !boot_reset_fuse_i)
      |-> vec_addr_o == BOOT_ADDR)
    else $error("boot reset address wrong");

  reset_first_a: assert property (@(posedge clk_i)
    reset_release_s |-> ##1 (fetch_valid_o && fetch_is_reset_o))
    else $error("reset vector not offered after reset");

  vector_spacing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && !fetch_is_reset_o && !$past(vector_table_select_i))
      |-> vec_addr_o == 16'({vec_num_o - 5'h01, 1'b0}))
    else $error("vector address not two words apart");

  relocated_table_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && !fetch_is_reset_o && $rose(fetch_valid_o) && $past(vector_table_select_i))
      |-> vec_addr_o == 16'(BOOT_ADDR + {vec_num_o - 5'h01, 1'b0}))
    else $error("relocated vector address wrong");

  ext_req_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.state == IVAU_IDLE && irq_i[0] && !vector_table_select_i)
      |=> fetch_valid_o && vec_addr_o == 16'h0002)
    else $error("external request 0 vector wrong");

  lowest_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.state == IVAU_IDLE && irq_i[1] && !irq_i[0]) |=> vec_num_o == 5'h03)
    else $error("priority order broken");

  small_variant_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fetch_valid_o |-> (LARGE_PINS || vec_num_o < 5'h18))
    else $error("absent pin change source raised");

  vector_held_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && !fetch_ack_i) |=> fetch_valid_o && $stable(vec_addr_o))
    else $error("vector changed before acknowledge");

  reset_num_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && fetch_is_reset_o) |-> vec_num_o == 5'h01)
    else $error("reset vector number wrong");

  // ==========================================
  // Table addresses, plain placement
  sequence plain_offer_s;
    $rose(fetch_valid_o) && !fetch_is_reset_o && !$past(vector_table_select_i);
  endsequence

  ext_req_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h02)) |-> vec_addr_o == 16'h0002)
    else $error("external request 0 vector address wrong");

  pin_chg0_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h03)) |-> vec_addr_o == 16'h0004)
    else $error("pin change 0 vector address wrong");

  pin_chg1_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h04)) |-> vec_addr_o == 16'h0006)
    else $error("pin change 1 vector address wrong");

  t2_cmp_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h05)) |-> vec_addr_o == 16'h0008)
    else $error("timer 2 compare vector address wrong");

  t2_ovf_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h06)) |-> vec_addr_o == 16'h000a)
    else $error("timer 2 overflow vector address wrong");

  t1_cap_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h07)) |-> vec_addr_o == 16'h000c)
    else $error("timer 1 capture vector address wrong");

  t1_cmpa_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h08)) |-> vec_addr_o == 16'h000e)
    else $error("timer 1 compare A vector address wrong");

  t1_cmpb_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h09)) |-> vec_addr_o == 16'h0010)
    else $error("timer 1 compare B vector address wrong");

  t1_ovf_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h0a)) |-> vec_addr_o == 16'h0012)
    else $error("timer 1 overflow vector address wrong");

  t0_cmp_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h0b)) |-> vec_addr_o == 16'h0014)
    else $error("timer 0 compare vector address wrong");

  t0_ovf_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h0c)) |-> vec_addr_o == 16'h0016)
    else $error("timer 0 overflow vector address wrong");

  spi_done_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h0d)) |-> vec_addr_o == 16'h0018)
    else $error("serial transfer vector address wrong");

  rx_done_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h0e)) |-> vec_addr_o == 16'h001a)
    else $error("receive complete vector address wrong");

  tx_empty_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h0f)) |-> vec_addr_o == 16'h001c)
    else $error("transmit buffer empty vector address wrong");

  tx_done_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h10)) |-> vec_addr_o == 16'h001e)
    else $error("transmit complete vector address wrong");

  us_start_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h11)) |-> vec_addr_o == 16'h0020)
    else $error("universal serial start vector address wrong");

  us_ovf_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h12)) |-> vec_addr_o == 16'h0022)
    else $error("universal serial overflow vector address wrong");

  comp_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h13)) |-> vec_addr_o == 16'h0024)
    else $error("analog comparator vector address wrong");

  conv_done_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h14)) |-> vec_addr_o == 16'h0026)
    else $error("converter done vector address wrong");

  nvm_ready_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h15)) |-> vec_addr_o == 16'h0028)
    else $error("data memory ready vector address wrong");

  store_ready_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h16)) |-> vec_addr_o == 16'h002a)
    else $error("program store ready vector address wrong");

  frame_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h17)) |-> vec_addr_o == 16'h002c)
    else $error("display frame vector address wrong");

  pin_chg2_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h18)) |-> vec_addr_o == 16'h002e)
    else $error("pin change 2 vector address wrong");

  pin_chg3_vec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (plain_offer_s ##0 (vec_num_o == 5'h19)) |-> vec_addr_o == 16'h0030)
    else $error("pin change 3 vector address wrong");

  // ==========================================
  // Table addresses, boot placement
  sequence moved_offer_s;
    $rose(fetch_valid_o) && !fetch_is_reset_o && $past(vector_table_select_i);
  endsequence

  moved_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (moved_offer_s ##0 (vec_num_o == 5'h02)) |-> vec_addr_o == 16'(BOOT_ADDR + 16'h0002))
    else $error("moved table start wrong");

  moved_mid_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (moved_offer_s ##0 (vec_num_o == 5'h0d)) |-> vec_addr_o == 16'(BOOT_ADDR + 16'h0018))
    else $error("moved serial transfer vector wrong");

  moved_last_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (moved_offer_s ##0 (vec_num_o == 5'h19)) |-> vec_addr_o == 16'(BOOT_ADDR + 16'h0030))
    else $error("moved last vector wrong");

  // ==========================================
  // Offer handshake
  offer_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && fetch_ack_i) |=> !fetch_valid_o)
    else $error("offer not withdrawn after acknowledge");

  irq_not_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (fetch_valid_o && !fetch_is_reset_o) |-> vec_num_o != 5'h01)
    else $error("interrupt offered as reset vector");
endmodule
